// *** pkg/dtc_pkg.sv ***
// Constants and types of the transmit control register bank
package dtc_pkg;
  localparam int NUM_PATHS = 2;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int SMSB_W = 6;
  localparam int PWR_W = 13;
  localparam int NUM_INT = 9;
  // Top interrupt enable, the one kept in the high register
  localparam int INT_TOP = NUM_INT - 1;
  // Register offsets
  localparam logic [11:0] ADDR_PWR_LOW = 12'h58b;
  localparam logic [11:0] ADDR_PWR_HIGH = 12'h58c;
  localparam logic [11:0] ADDR_TX_SM = 12'h58d;
  localparam logic [11:0] ADDR_BLANK = 12'h596;
  localparam logic [11:0] ADDR_INT_LOW = 12'h597;
  localparam logic [11:0] ADDR_INT_HIGH = 12'h598;
  localparam logic [11:0] ADDR_FLUSH = 12'h599;
  localparam logic [11:0] ADDR_BOOT = 12'h705;
  localparam logic [11:0] ADDR_PLL_PD0 = 12'h790;
  // Field positions
  localparam int BIT_SM_EN = 0;
  localparam int BIT_SOFT_OVR = 2;
  localparam int BIT_SOFT_VAL = 3;
  localparam int BIT_FLUSH = 0;
  localparam int BIT_BOOT = 0;
  localparam int BIT_INT_HIGH = 0;
  localparam int PWR_HIGH_LSB = 8;
  // Reset values
  localparam logic RST_SM_EN = 1'b0;
  localparam logic RST_FLUSH = 1'b1;
  localparam logic [6:0] TX_SM_RSVD = 7'h01;
  localparam logic [8:0] RST_INT_EN = 9'h000;
  localparam logic [7:0] RST_PLL_PD0 = 8'h00;
  // Averaging window of the short power detector
  localparam int AVG_SHIFT = 2;
  localparam logic [1:0] AVG_LAST = 2'h3;
  typedef logic [NUM_PATHS-1:0] dtc_path_t;
endpackage

// *** src/dtc_power_avg.sv ***
// Short average power detector of one main path
`timescale 1ns/100ps
module dtc_power_avg
  import dtc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Sample stream
  input wire logic sample_valid,
  input wire logic [SMSB_W-1:0] i_msb,
  input wire logic [SMSB_W-1:0] q_msb,
  // Averaged result
  output logic [PWR_W-1:0] power_avg
);
  logic [10:0] i_sq;
  logic [10:0] q_sq;
  logic [11:0] inst_pwr;
  logic [13:0] acc_reg, acc_next;
  logic [1:0] cnt_reg, cnt_next;
  logic [PWR_W-1:0] avg_reg, avg_next;

  // Instantaneous power from signed six-bit samples
  assign i_sq = 11'($signed(i_msb) * $signed(i_msb));
  assign q_sq = 11'($signed(q_msb) * $signed(q_msb));
  assign inst_pwr = {1'b0, i_sq} + {1'b0, q_sq};

  // Accumulate a short window and publish its mean
  always_comb
  begin
    acc_next = acc_reg;
    cnt_next = cnt_reg;
    avg_next = avg_reg;
    if (sample_valid)
    begin
      cnt_next = cnt_reg + 2'h1;
      if (cnt_reg == AVG_LAST)
      begin
        avg_next = PWR_W'((acc_reg + 14'(inst_pwr)) >> AVG_SHIFT);
        acc_next = '0;
      end
      else
        acc_next = acc_reg + 14'(inst_pwr);
    end
  end

  // Detector registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      acc_reg <= '0;
      cnt_reg <= '0;
      avg_reg <= '0;
    end
    else
    begin
      acc_reg <= acc_next;
      cnt_reg <= cnt_next;
      avg_reg <= avg_next;
    end
  end

  assign power_avg = avg_reg;
endmodule // dtc_power_avg

// *** src/dtc_tx_regs.sv ***
// Transmit control and status register bank of the dual DAC
`timescale 1ns/100ps
module dtc_tx_regs
  import dtc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register access from the serial port decoder
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // Page selector, one bit per main path
  input wire logic [NUM_PATHS-1:0] main_path_page_select,
  // Main path sample streams
  input wire logic [NUM_PATHS-1:0] sample_valid,
  input wire logic [NUM_PATHS-1:0][SMSB_W-1:0] i_sample_msb,
  input wire logic [NUM_PATHS-1:0][SMSB_W-1:0] q_sample_msb,
  // Transmit enable pins and controls
  input wire logic [NUM_PATHS-1:0] transmit_enable_pin,
  output logic [NUM_PATHS-1:0] transmit_enable,
  output logic [NUM_PATHS-1:0] tx_sm_enable,
  output logic [NUM_PATHS-1:0] flush_enable,
  // Link interrupt conditions
  input wire logic [NUM_INT-1:0] link_int_events,
  output logic [NUM_INT-1:0] link_int_request,
  // Bootloader handshake
  input wire logic bootloader_done,
  input wire logic bootloader_fail,
  output logic bootloader_start,
  // PLL power-down controls
  output logic [DATA_W-1:0] pll_powerdown_control
);
  // Lowest selected path, used to pick read data
  function automatic int unsigned read_path(input dtc_path_t sel);
    read_path = 0;
    for (int k = NUM_PATHS - 1; k >= 0; k--)
      if (sel[k])
        read_path = k;
  endfunction

  // Write strobe for one register offset
  function automatic logic wr_hit(input logic [ADDR_W-1:0] a,
                                  input logic [ADDR_W-1:0] off,
                                  input logic wr);
    wr_hit = wr && (a == off);
  endfunction

  dtc_path_t tx_sm_reg, tx_sm_next;
  dtc_path_t soft_ovr_reg, soft_ovr_next;
  dtc_path_t soft_val_reg, soft_val_next;
  dtc_path_t flush_reg, flush_next;
  dtc_path_t transmit_enable_reg, transmit_enable_next;
  dtc_path_t pin_meta_reg, pin_sync_reg;
  logic [NUM_INT-1:0] int_en_reg, int_en_next;
  logic [NUM_INT-1:0] int_req_reg, int_req_next;
  logic boot_reg, boot_next;
  logic [DATA_W-1:0] pll_pd_reg, pll_pd_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic [NUM_PATHS-1:0][PWR_W-1:0] power_avg;
  int unsigned rp;

  // One power detector per main path
  genvar g;
  generate
    for (g = 0; g < NUM_PATHS; g++)
    begin : g_pwr
      dtc_power_avg u_pwr (
        .clk(clk),
        .rst_n(rst_n),
        .sample_valid(sample_valid[g]),
        .i_msb(i_sample_msb[g]),
        .q_msb(q_sample_msb[g]),
        .power_avg(power_avg[g])
      );
    end
  endgenerate

  // Pin synchroniser, first stage read only by the second
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end
    else
    begin
      pin_meta_reg <= transmit_enable_pin;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Paged path controls, written on every selected path
  always_comb
  begin
    tx_sm_next = tx_sm_reg;
    soft_ovr_next = soft_ovr_reg;
    soft_val_next = soft_val_reg;
    flush_next = flush_reg;
    for (int p = 0; p < NUM_PATHS; p++)
    begin
      if (main_path_page_select[p])
      begin
        if (wr_hit(reg_addr, ADDR_TX_SM, reg_wr))
          tx_sm_next[p] = reg_wdata[BIT_SM_EN];
        if (wr_hit(reg_addr, ADDR_BLANK, reg_wr))
        begin
          soft_ovr_next[p] = reg_wdata[BIT_SOFT_OVR];
          soft_val_next[p] = reg_wdata[BIT_SOFT_VAL];
        end
        if (wr_hit(reg_addr, ADDR_FLUSH, reg_wr))
          flush_next[p] = reg_wdata[BIT_FLUSH];
      end
    end
  end

  // Transmit enable source per path
  always_comb
  begin
    for (int p = 0; p < NUM_PATHS; p++)
      transmit_enable_next[p] = soft_ovr_reg[p] ? soft_val_reg[p]
                                     : pin_sync_reg[p];
  end

  // Path control registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tx_sm_reg <= {NUM_PATHS{RST_SM_EN}};
      soft_ovr_reg <= '0;
      soft_val_reg <= '0;
      flush_reg <= {NUM_PATHS{RST_FLUSH}};
      transmit_enable_reg <= '0;
    end
    else
    begin
      tx_sm_reg <= tx_sm_next;
      soft_ovr_reg <= soft_ovr_next;
      soft_val_reg <= soft_val_next;
      flush_reg <= flush_next;
      transmit_enable_reg <= transmit_enable_next;
    end
  end

  // Global controls: interrupt enables, bootloader, PLL power-down
  always_comb
  begin
    int_en_next = int_en_reg;
    boot_next = boot_reg;
    pll_pd_next = pll_pd_reg;
    if (wr_hit(reg_addr, ADDR_INT_LOW, reg_wr))
      int_en_next[INT_TOP-1:0] = reg_wdata;
    if (wr_hit(reg_addr, ADDR_INT_HIGH, reg_wr))
      int_en_next[INT_TOP] = reg_wdata[BIT_INT_HIGH];
    if (wr_hit(reg_addr, ADDR_PLL_PD0, reg_wr))
      pll_pd_next = reg_wdata;
    // Self clear on completion; a new start in the same cycle wins
    if (bootloader_done || bootloader_fail)
      boot_next = 1'b0;
    if (wr_hit(reg_addr, ADDR_BOOT, reg_wr) && reg_wdata[BIT_BOOT])
      boot_next = 1'b1;
    // Each condition passes only under its own enable
    int_req_next = link_int_events & int_en_reg;
  end

  // Global control registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      int_en_reg <= RST_INT_EN;
      int_req_reg <= '0;
      boot_reg <= 1'b0;
      pll_pd_reg <= RST_PLL_PD0;
    end
    else
    begin
      int_en_reg <= int_en_next;
      int_req_reg <= int_req_next;
      boot_reg <= boot_next;
      pll_pd_reg <= pll_pd_next;
    end
  end

  // Read mux, answered one cycle after the read strobe
  assign rp = read_path(main_path_page_select);
  always_comb
  begin
    rdata_next = '0;
    if (reg_rd)
    begin
      unique case (reg_addr)
        ADDR_PWR_LOW: rdata_next = power_avg[rp][7:0];
        ADDR_PWR_HIGH:
          rdata_next = {3'h0, power_avg[rp][PWR_W-1:PWR_HIGH_LSB]};
        ADDR_TX_SM: rdata_next = {TX_SM_RSVD, tx_sm_reg[rp]};
        ADDR_BLANK:
          rdata_next = {4'h0, soft_val_reg[rp], soft_ovr_reg[rp], 2'h0};
        ADDR_INT_LOW: rdata_next = int_en_reg[INT_TOP-1:0];
        ADDR_INT_HIGH: rdata_next = {7'h00, int_en_reg[INT_TOP]};
        ADDR_FLUSH: rdata_next = {7'h00, flush_reg[rp]};
        ADDR_BOOT: rdata_next = {7'h00, boot_reg};
        ADDR_PLL_PD0: rdata_next = pll_pd_reg;
        default: rdata_next = '0;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata_reg <= '0;
    else
      rdata_reg <= rdata_next;
  end

  // Outputs straight from flip-flops
  assign reg_rdata = rdata_reg;
  assign transmit_enable = transmit_enable_reg;
  assign tx_sm_enable = tx_sm_reg;
  assign flush_enable = flush_reg;
  assign link_int_request = int_req_reg;
  assign bootloader_start = boot_reg;
  assign pll_powerdown_control = pll_pd_reg;

  // Checks on the register bank
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_pwr_high;
    reg_rd && reg_addr == ADDR_PWR_HIGH && main_path_page_select[0]
      |=> reg_rdata == {3'h0, $past(power_avg[0][12:8])};
  endproperty
  a_pwr_high: assert property (p_pwr_high)
    else $error("Power high byte readback wrong");

  property p_page_write;
    reg_wr && reg_addr == ADDR_FLUSH && main_path_page_select == 2'h2
      |=> flush_reg[0] == $past(flush_reg[0])
          && flush_reg[1] == $past(reg_wdata[0]);
  endproperty
  a_page_write: assert property (p_page_write)
    else $error("Paged write reached the wrong path");

  property p_sm_write;
    reg_wr && reg_addr == ADDR_TX_SM && main_path_page_select[0]
      |=> tx_sm_enable[0] == $past(reg_wdata[0]);
  endproperty
  a_sm_write: assert property (p_sm_write)
    else $error("State machine enable not written");

  property p_pin_path;
    !soft_ovr_reg[0] && !$past(soft_ovr_reg[0])
      |-> transmit_enable[0] == $past(pin_meta_reg[0], 2);
  endproperty
  a_pin_path: assert property (p_pin_path)
    else $error("Transmit enable does not follow the pin");

  property p_soft_val;
    reg_wr && reg_addr == ADDR_BLANK && main_path_page_select[1]
      && reg_wdata[2] |=> ##1 transmit_enable[1] == $past(reg_wdata[3], 2);
  endproperty
  a_soft_val: assert property (p_soft_val)
    else $error("Soft transmit enable value not applied");

  property p_int_high;
    reg_wr && reg_addr == ADDR_INT_HIGH
      |=> int_en_reg[8] == $past(reg_wdata[0])
          && int_en_reg[7:0] == $past(int_en_reg[7:0]);
  endproperty
  a_int_high: assert property (p_int_high)
    else $error("Interrupt enable bit 8 write wrong");

  property p_int_gate;
    ##1 link_int_request == ($past(link_int_events) & $past(int_en_reg));
  endproperty
  a_int_gate: assert property (p_int_gate)
    else $error("Interrupt request not gated by its enable");

  property p_cgs_gate;
    !int_en_reg[8] |=> !link_int_request[8];
  endproperty
  a_cgs_gate: assert property (p_cgs_gate)
    else $error("Masked sync condition raised a request");

  property p_fifo_gate;
    link_int_events[0] && int_en_reg[0] |=> link_int_request[0];
  endproperty
  a_fifo_gate: assert property (p_fifo_gate)
    else $error("Enabled FIFO condition lost");

  property p_boot_clear;
    bootloader_start && (bootloader_done || bootloader_fail)
      && !(reg_wr && reg_addr == ADDR_BOOT && reg_wdata[0])
      |=> !bootloader_start;
  endproperty
  a_boot_clear: assert property (p_boot_clear)
    else $error("Bootloader bit did not clear");

  property p_boot_set;
    reg_wr && reg_addr == ADDR_BOOT && reg_wdata[0] |=> bootloader_start;
  endproperty
  a_boot_set: assert property (p_boot_set)
    else $error("Bootloader start lost");

  property p_flush_hold;
    !(reg_wr && reg_addr == ADDR_FLUSH) |=> $stable(flush_enable);
  endproperty
  a_flush_hold: assert property (p_flush_hold)
    else $error("Flush enable changed without a write");

  c_override: cover property (soft_ovr_reg[0] ##1 transmit_enable[0]);
  c_boot_run: cover property (bootloader_start ##[1:20] bootloader_done);
  c_int_req: cover property (link_int_request[8]);
  c_pwr_read: cover property (reg_rd && reg_addr == ADDR_PWR_HIGH);
endmodule // dtc_tx_regs

// *** tb/dtc_testbench.sv ***
// Self-checking bench of the transmit control register bank
`timescale 1ns/100ps
module testbench
  import dtc_pkg::*;
;
  // One table row: paged write then read back
  typedef struct packed {
    logic [11:0] addr;
    logic [1:0] page;
    logic [7:0] wdata;
    logic [7:0] rexp;
  } dtc_row_t;

  localparam dtc_row_t ROWS [11] = '{
    '{12'h58d, 2'h1, 8'hff, 8'h03},
    '{12'h58d, 2'h2, 8'h00, 8'h02},
    '{12'h596, 2'h1, 8'hff, 8'h0c},
    '{12'h597, 2'h1, 8'ha5, 8'ha5},
    '{12'h598, 2'h1, 8'hff, 8'h01},
    '{12'h599, 2'h2, 8'hfe, 8'h00},
    '{12'h790, 2'h1, 8'h5a, 8'h5a},
    '{12'h705, 2'h1, 8'h00, 8'h00},
    '{12'h123, 2'h1, 8'hff, 8'h00},
    '{12'h58b, 2'h1, 8'hff, 8'h00},
    '{12'h58c, 2'h1, 8'hff, 8'h00}
  };

  // Stimulus, all defined at time zero
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [1:0] main_path_page_select = 2'h1;
  logic [1:0] sample_valid = 2'h0;
  logic [1:0][5:0] i_sample_msb = '0;
  logic [1:0][5:0] q_sample_msb = '0;
  logic [1:0] transmit_enable_pin = 2'h0;
  logic [8:0] link_int_events = 9'h000;
  logic bootloader_done = 1'b0;
  logic bootloader_fail = 1'b0;
  // Observed outputs
  logic [7:0] reg_rdata;
  logic [1:0] transmit_enable;
  logic [1:0] tx_sm_enable;
  logic [1:0] flush_enable;
  logic [8:0] link_int_request;
  logic bootloader_start;
  logic [7:0] pll_powerdown_control;
  int n_mismatch = 0;
  int samples_checked = 0;

  // 20 MHz clock
  always #25 clk = ~clk;

  dtc_tx_regs u_dut (
    .clk(clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .main_path_page_select(main_path_page_select),
    .sample_valid(sample_valid),
    .i_sample_msb(i_sample_msb),
    .q_sample_msb(q_sample_msb),
    .transmit_enable_pin(transmit_enable_pin),
    .transmit_enable(transmit_enable),
    .tx_sm_enable(tx_sm_enable),
    .flush_enable(flush_enable),
    .link_int_events(link_int_events),
    .link_int_request(link_int_request),
    .bootloader_done(bootloader_done),
    .bootloader_fail(bootloader_fail),
    .bootloader_start(bootloader_start),
    .pll_powerdown_control(pll_powerdown_control)
  );

  // Compare one value and count it
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      n_mismatch++;
    end
  endtask

  // One-cycle write strobe, entered just after an edge
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read strobe, data checked in the following cycle
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, e);
    @(posedge clk);
  endtask

  // Reset held for 8 cycles
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  // Verdict, reached from the main flow or the watchdog
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog against a hang
  initial
  begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    tally_and_finish;
  end

  // Main sequence
  initial
  begin
    @(posedge clk);
    do_reset;
    foreach (ROWS[k])
    begin
      main_path_page_select <= ROWS[k].page;
      wr(ROWS[k].addr, ROWS[k].wdata);
      rd_chk(ROWS[k].addr, ROWS[k].rexp);
    end
    check(tx_sm_enable, 2'h1);
    check(flush_enable, 2'h1);
    check(transmit_enable, 2'h1);
    check(pll_powerdown_control, 8'h5a);
    $display("test table done");
    // Reset in mid-run restores every default
    do_reset;
    check({transmit_enable, tx_sm_enable, flush_enable}, 6'h03);
    check(link_int_request, 9'h000);
    check(bootloader_start, 1'b0);
    check(pll_powerdown_control, 8'h00);
    main_path_page_select <= 2'h2;
    rd_chk(12'h58d, 8'h02);
    rd_chk(12'h596, 8'h00);
    rd_chk(12'h597, 8'h00);
    rd_chk(12'h598, 8'h00);
    rd_chk(12'h599, 8'h01);
    rd_chk(12'h705, 8'h00);
    rd_chk(12'h790, 8'h00);
    $display("test reset done");
    // Pin path through the synchroniser, then soft override
    transmit_enable_pin <= 2'h1;
    repeat (2) @(posedge clk);
    #1 check(transmit_enable, 2'h0);
    @(posedge clk);
    #1 check(transmit_enable, 2'h1);
    @(posedge clk);
    main_path_page_select <= 2'h1;
    wr(12'h596, 8'h04);
    @(posedge clk);
    #1 check(transmit_enable, 2'h0);
    @(posedge clk);
    main_path_page_select <= 2'h3;
    wr(12'h596, 8'h0c);
    @(posedge clk);
    #1 check(transmit_enable, 2'h3);
    @(posedge clk);
    $display("test override done");
    // Walk each link condition, then drop single enables
    wr(12'h597, 8'hff);
    @(posedge clk);
    wr(12'h598, 8'h01);
    for (int i = 0; i < 9; i++)
    begin
      link_int_events <= 9'h001 << i;
      @(posedge clk);
      #1 check(link_int_request, 9'h001 << i);
      @(posedge clk);
    end
    link_int_events <= 9'h1ff;
    wr(12'h597, 8'hfe);
    @(posedge clk);
    #1 check(link_int_request, 9'h1fe);
    @(posedge clk);
    wr(12'h598, 8'h00);
    @(posedge clk);
    #1 check(link_int_request, 9'h0fe);
    @(posedge clk);
    link_int_events <= 9'h000;
    $display("test interrupts done");
    // Start, clear on failure, start racing done, clear on done
    wr(12'h705, 8'h01);
    #1 check(bootloader_start, 1'b1);
    @(posedge clk);
    bootloader_fail <= 1'b1;
    @(posedge clk);
    bootloader_fail <= 1'b0;
    #1 check(bootloader_start, 1'b0);
    @(posedge clk);
    bootloader_done <= 1'b1;
    wr(12'h705, 8'h01);
    bootloader_done <= 1'b0;
    #1 check(bootloader_start, 1'b1);
    @(posedge clk);
    bootloader_done <= 1'b1;
    @(posedge clk);
    bootloader_done <= 1'b0;
    #1 check(bootloader_start, 1'b0);
    @(posedge clk);
    $display("test bootloader done");
    // Extreme codes on path 0, small ones on path 1
    i_sample_msb <= {6'h03, 6'h20};
    q_sample_msb <= {6'h04, 6'h1f};
    sample_valid <= 2'h3;
    repeat (4) @(posedge clk);
    sample_valid <= 2'h0;
    @(posedge clk);
    main_path_page_select <= 2'h3;
    rd_chk(12'h58b, 8'hc1);
    rd_chk(12'h58c, 8'h07);
    main_path_page_select <= 2'h2;
    rd_chk(12'h58b, 8'h19);
    rd_chk(12'h58c, 8'h00);
    $display("test power done");
    tally_and_finish;
  end
endmodule // testbench
